// ---- fes_pkg.sv ----
// Package for the flash erase and unsecure command sequencer
package fes_pkg;
	localparam logic [7:0] CMD_ERASE_SECTOR = 8'h0A;
	localparam logic [7:0] CMD_UNSECURE = 8'h0B;
	localparam logic [2:0] IDX_ERASE_LAST = 3'h1;
	localparam logic [2:0] IDX_UNSEC_LAST = 3'h0;
	localparam int CCOB_WORDS = 6;
	// APB byte offsets
	localparam logic [7:0] OFS_INDEX = 8'h00;
	localparam logic [7:0] OFS_DATA = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_CONFIG = 8'h0C;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
	localparam logic [7:0] OFS_SECURE = 8'h18;
	// Status bit positions
	localparam int ST_COMMAND_COMPLETE_FLAG = 7;
	localparam int ST_ACCESS_ERROR_FLAG = 5;
	localparam int ST_PVIOL = 4;
	localparam int ST_VERR = 1;
	localparam int ST_VUNC = 0;
	// Config register fields
	localparam int CF_PSIZE_LSB = 0;
	localparam int CF_EEPROT_LSB = 8;
	localparam int CF_PPROT = 16;
	localparam int CF_EPROT = 17;
	localparam int CF_CMDOK_LSB = 18;
	localparam int CF_INJ_ERR = 30;
	localparam int CF_INJ_UNC = 31;
	localparam logic [4:0] EEPROT_MAX_CODE = 5'h0F;
	localparam logic [17:0] EEPROT_BASE = 18'h00400;
	localparam logic [17:0] EEPROT_STEP = 18'h00020;
	// Interrupt bits: 0 complete, 1 error
	localparam int IRQ_BITS = 2;
	localparam logic [15:0] PFLASH_BLOCKS = 16'h0003;
	localparam int ERASE_TIME_US = 20;
	localparam int CLK_MHZ = 25;
	localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
	localparam logic SECURE_RESET = 1'b1;

	typedef struct packed {
		logic start;
		logic whole;
		logic [17:0] addr;
	} fes_erase_req_t;

	typedef struct packed {
		logic done;
		logic verifyErr;
		logic verifyUnc;
	} fes_erase_rsp_t;
endpackage

// ---- fes_protect_decode.sv ----
// EEPROM protection range decode
`timescale 1ns/100ps
module fes_protect_decode
	import fes_pkg::*;
(
	input wire logic [4:0] eepromProtectSize,
	input wire logic eepromProtectEn,
	output logic [17:0] protectLast
);
	wire logic [4:0] clipped;
	wire logic [17:0] span;
	// Codes above 01111 all give the largest 512 byte range
	assign clipped = (eepromProtectSize > EEPROT_MAX_CODE) ?
		EEPROT_MAX_CODE : eepromProtectSize;
	assign span = 18'(({13'h0, clipped} + 18'h1) * EEPROT_STEP);
	assign protectLast = eepromProtectEn ? 18'(EEPROT_BASE + span - 18'h1) :
		18'h0;
endmodule

// ---- fes_erase_engine.sv ----
// Timed erase and verify engine standing in for the array
`timescale 1ns/100ps
module fes_erase_engine
	import fes_pkg::*;
#(
	parameter int ERASE_CNT = ERASE_CYCLES
)(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic clkEn,
	input wire fes_erase_req_t req,
	input wire logic injectErr,
	input wire logic injectUnc,
	output fes_erase_rsp_t rsp
);
	// The countdown register is 16 bits wide
	if (ERASE_CNT < 1 || ERASE_CNT > 65535)
		$error("ERASE_CNT out of range");
	logic [15:0] count;
	logic busy;
	wire logic lastTick = busy && count == 16'h0001;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			count <= 16'h0000;
			busy <= 1'b0;
			rsp <= '0;
		end else if (clkEn) begin
			rsp.done <= lastTick;
			if (req.start) begin
				busy <= 1'b1;
				count <= 16'(ERASE_CNT);
			end else if (busy) begin
				count <= count - 16'h0001;
				busy <= !lastTick;
			end
			// Verify result sampled at end of erase
			if (lastTick) begin
				rsp.verifyErr <= injectErr | injectUnc;
				rsp.verifyUnc <= injectUnc;
			end
		end
	end
endmodule

// ---- fes_sequencer.sv ----
// Flash erase-sector and unsecure command sequencer with APB registers
//
// Summary of operation
// - six 16-bit command words, 3-bit index, byte access
// - EEPROM protect size: 32-byte steps, max 512
// - sector erase needs final index 001
// - command not allowed in mode: access error
// - invalid block bits 17:16: access error
// - address bits 2:0 nonzero: access error
// - protected sector sets protection violation
// - verify errors set verify flags
// - code 0B at index 000 is unsecure
// - unsecure erases all, releases security if verified
// - failed verify keeps security, sets verify error
// - complete flag sets after unsecure, pass or fail
// - unsecure needs final index 000
// - any protection blocks unsecure
// - sector erase: code 0A, address at 000/001
// - command writes ignored while complete flag low
`timescale 1ns/100ps
module fes_sequencer
	import fes_pkg::*;
#(
	parameter int ERASE_CNT = ERASE_CYCLES
)(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic clkEn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic secured
);
	typedef enum logic [1:0] {IDLE, ERASING} fes_state_t;
	fes_state_t state;

	logic [2:0] commandIndex;
	logic [15:0] commandWords [CCOB_WORDS];
	logic commandCompleteFlag;
	logic accessErrorFlag;
	logic protectionViolationFlag;
	logic verifyErrorFlag;
	logic verifyUncorrectableFlag;
	logic [31:0] cfgReg;
	logic [IRQ_BITS-1:0] irqStat;
	logic [IRQ_BITS-1:0] irqMask;
	logic isUnsecure;
	fes_erase_req_t eraseReq;
	fes_erase_rsp_t eraseRsp;
	logic [17:0] protectLast;

	// Index field reaches eight words; two interrupt events
	if (CCOB_WORDS < 1 || CCOB_WORDS > 8)
		$error("command array size outside index reach");
	if (IRQ_BITS != 2)
		$error("interrupt layout needs exactly two bits");

	wire logic access = psel && penable;
	wire logic wr = access && pwrite;
	wire logic hitIndex = paddr == OFS_INDEX;
	wire logic hitData = paddr == OFS_DATA;
	wire logic hitStatus = paddr == OFS_STATUS;
	wire logic hitConfig = paddr == OFS_CONFIG;
	wire logic hitIrqStat = paddr == OFS_IRQ_STAT;
	wire logic hitIrqMask = paddr == OFS_IRQ_MASK;
	wire logic hitSecure = paddr == OFS_SECURE;
	wire logic mapped = hitIndex | hitData | hitStatus | hitConfig |
		hitIrqStat | hitIrqMask | hitSecure;
	wire logic indexValid = commandIndex < 3'(CCOB_WORDS);

	// Command code sits in the high byte of word 0
	wire logic [7:0] cmdCode = commandWords[0][15:8];
	wire logic [1:0] blockSel = commandWords[0][1:0];
	wire logic [17:0] eraseAddr = {blockSel, commandWords[1]};
	wire logic [4:0] eepromProtectSize = cfgReg[CF_EEPROT_LSB +: 5];
	wire logic eepromProtectEn = cfgReg[CF_EPROT];
	wire logic [7:0] pflashProtSectors = cfgReg[CF_PSIZE_LSB +: 8];
	wire logic pflashProtEn = cfgReg[CF_PPROT];
	wire logic [1:0] cmdAllowed = cfgReg[CF_CMDOK_LSB +: 2];

	// Status write: accepted launch clears the complete flag, access error and protection violation write-one-clear
	wire logic statusWr = wr && hitStatus && pstrb[0];
	wire logic launch = statusWr && pwdata[ST_COMMAND_COMPLETE_FLAG] && commandCompleteFlag
		&& state == IDLE && !accessErrorFlag && !protectionViolationFlag;
	wire logic isErase = cmdCode == CMD_ERASE_SECTOR;
	wire logic isUnsec = cmdCode == CMD_UNSECURE;

	// P-Flash protection: lowest 512-byte sectors, config field count plus one
	wire logic [17:0] pprotLast = 18'({pflashProtSectors, 9'h1FF});
	wire logic sectorProt = (pflashProtEn && eraseAddr <= pprotLast) ||
		(eepromProtectEn && eraseAddr[17:9] == protectLast[17:9]) ||
		(eepromProtectEn && eraseAddr >= EEPROT_BASE &&
		eraseAddr <= protectLast);
	wire logic anyProt = pflashProtEn || eepromProtectEn;

	wire logic eraseAccErr = (commandIndex != IDX_ERASE_LAST) ||
		!cmdAllowed[0] ||
		!PFLASH_BLOCKS[blockSel] ||
		(eraseAddr[2:0] != 3'h0);
	wire logic unsecAccErr = (commandIndex != IDX_UNSEC_LAST) ||
		!cmdAllowed[1];
	wire logic launchAccErr = isErase ? eraseAccErr :
		isUnsec ? unsecAccErr : 1'b1;
	wire logic launchProtErr = !launchAccErr &&
		(isErase ? sectorProt : anyProt);
	wire logic launchOk = launch && !launchAccErr && !launchProtErr;
	wire logic launchFail = launch && !launchOk;

	wire logic eventDone = eraseRsp.done || launchFail;
	wire logic eventErr = launchFail || (eraseRsp.done && eraseRsp.verifyErr);
	wire logic [IRQ_BITS-1:0] irqSet = {eventErr, eventDone};
	wire logic [IRQ_BITS-1:0] irqClr = (wr && hitIrqStat) ?
		pwdata[IRQ_BITS-1:0] : '0;

	fes_protect_decode u_protect (
		.eepromProtectSize(eepromProtectSize),
		.eepromProtectEn(eepromProtectEn),
		.protectLast(protectLast)
	);

	fes_erase_engine #(.ERASE_CNT(ERASE_CNT)) u_engine (
		.mclk(mclk),
		.rstn(rstn),
		.clkEn(clkEn),
		.req(eraseReq),
		.injectErr(cfgReg[CF_INJ_ERR]),
		.injectUnc(cfgReg[CF_INJ_UNC]),
		.rsp(eraseRsp)
	);

	assign eraseReq.start = launchOk;
	assign eraseReq.whole = isUnsec;
	assign eraseReq.addr = eraseAddr;

	// Command array; writes dropped while a command runs
	wire logic dataWr = wr && hitData && commandCompleteFlag && indexValid;
	always_ff @(posedge mclk) begin
		if (clkEn && dataWr) begin
			if (pstrb[0])
				commandWords[commandIndex][7:0] <= pwdata[7:0];
			if (pstrb[1])
				commandWords[commandIndex][15:8] <= pwdata[15:8];
		end
	end

	wire logic indexWr = wr && hitIndex && pstrb[0] &&
		commandCompleteFlag;
	wire logic cfgWr = wr && hitConfig && state == IDLE;
	wire logic maskWr = wr && hitIrqMask;
	wire logic idleStatusWr = statusWr && state == IDLE;
	wire logic clearAcc = idleStatusWr && pwdata[ST_ACCESS_ERROR_FLAG];
	wire logic clearProt = idleStatusWr && pwdata[ST_PVIOL];
	wire logic eraseDone = state == ERASING && eraseRsp.done;
	// Failed verify leaves security as it was
	wire logic secureRelease = eraseDone && isUnsecure &&
		!eraseRsp.verifyErr;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			commandIndex <= 3'h0;
		else if (clkEn && indexWr)
			commandIndex <= pwdata[2:0];
	end

	// Protection setup is frozen while a command runs
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			cfgReg <= 32'h0000_0000;
		else if (clkEn && cfgWr)
			cfgReg <= pwdata;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			irqMask <= '0;
		else if (clkEn && maskWr)
			irqMask <= pwdata[IRQ_BITS-1:0];
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			irqStat <= '0;
		else if (clkEn)
			irqStat <= (irqStat & ~irqClr) | irqSet;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			state <= IDLE;
		else if (clkEn) begin
			unique case (state)
				IDLE:
					if (launchOk)
						state <= ERASING;
				ERASING:
					if (eraseRsp.done)
						state <= IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			commandCompleteFlag <= 1'b1;
		else if (clkEn && launchOk)
			commandCompleteFlag <= 1'b0;
		else if (clkEn && eraseDone)
			commandCompleteFlag <= 1'b1;
	end

	// Launch result outranks a clear in the same write
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			accessErrorFlag <= 1'b0;
		else if (clkEn && launch)
			accessErrorFlag <= launchAccErr;
		else if (clkEn && clearAcc)
			accessErrorFlag <= 1'b0;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			protectionViolationFlag <= 1'b0;
		else if (clkEn && launch)
			protectionViolationFlag <= launchProtErr;
		else if (clkEn && clearProt)
			protectionViolationFlag <= 1'b0;
	end

	// Verify flags keep the last result until a new launch
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			verifyErrorFlag <= 1'b0;
			verifyUncorrectableFlag <= 1'b0;
		end else if (clkEn && launch) begin
			verifyErrorFlag <= 1'b0;
			verifyUncorrectableFlag <= 1'b0;
		end else if (clkEn && eraseDone) begin
			verifyErrorFlag <= eraseRsp.verifyErr;
			verifyUncorrectableFlag <= eraseRsp.verifyUnc;
		end
	end

	// Remembers which command runs, for the finish step
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			isUnsecure <= 1'b0;
		else if (clkEn && launch)
			isUnsecure <= isUnsec;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			secured <= SECURE_RESET;
		else if (clkEn && secureRelease)
			secured <= 1'b0;
	end

	logic [31:0] statusWord;
	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[ST_COMMAND_COMPLETE_FLAG] = commandCompleteFlag;
		statusWord[ST_ACCESS_ERROR_FLAG] = accessErrorFlag;
		statusWord[ST_PVIOL] = protectionViolationFlag;
		statusWord[ST_VERR] = verifyErrorFlag;
		statusWord[ST_VUNC] = verifyUncorrectableFlag;
	end
	wire logic [15:0] dataWord = indexValid ? commandWords[commandIndex] :
		16'h0000;
	// Unmapped offsets and index slots 6 and 7 read as zero
	wire logic [31:0] readMux =
		hitIndex ? {29'h0, commandIndex} :
		hitData ? {16'h0, dataWord} :
		hitStatus ? statusWord :
		hitConfig ? cfgReg :
		hitIrqStat ? 32'(irqStat) :
		hitIrqMask ? 32'(irqMask) :
		hitSecure ? {31'h0, secured} : 32'h0000_0000;

	// Read data is latched at setup, so no wait state is needed
	assign pready = 1'b1;
	assign pslverr = access && !mapped;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			prdata <= 32'h0000_0000;
		else if (clkEn && psel && !penable && !pwrite)
			prdata <= readMux;
	end
	assign irq = |(irqStat & irqMask);
endmodule

// ---- fes_sequencer_assertions.sv ----
// Port-level checker for the flash command sequencer
`timescale 1ns/100ps
module fes_sequencer_assertions
	import fes_pkg::*;
#(
	parameter int ERASE_CNT = ERASE_CYCLES
)(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic clkEn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq,
	input wire logic secured
);
	localparam int LAT_MIN = ERASE_CNT - 1;
	localparam int LAT_MAX = ERASE_CNT + 5;
	logic [15:0] sinceLaunch;
	wire access = psel && penable;
	wire mapped = paddr <= OFS_SECURE && paddr[1:0] == 2'h0;
	wire launchNow = access && pwrite && paddr == OFS_STATUS && pwdata[ST_COMMAND_COMPLETE_FLAG];
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence sMaskOff;
		access && pwrite && paddr == OFS_IRQ_MASK && pwdata[1:0] == 2'h0;
	endsequence
	sequence sSecDrop;
		secured ##1 !secured;
	endsequence
	// Saturates so a stale launch never looks recent
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			sinceLaunch <= 16'hFFFF;
		else if (launchNow)
			sinceLaunch <= 16'h0;
		else if (sinceLaunch != 16'hFFFF)
			sinceLaunch <= sinceLaunch + 16'h1;
	end
	chk_ready_now: assert property (access |-> pready)
		else $error("pready low in access phase");
	chk_slverr_bad: assert property (access && !mapped |-> pslverr)
		else $error("no slave error on unmapped access");
	chk_slverr_ok: assert property (access && mapped |-> !pslverr)
		else $error("slave error on mapped access");
	chk_unmapped_zero: assert property (access && !pwrite && !mapped |->
		prdata == 32'h0)
		else $error("unmapped read not zero");
	chk_reset_vals: assert property ($rose(rstn) |-> secured && !irq)
		else $error("wrong state after reset");
	chk_secure_rise: assert property (!$rose(secured))
		else $error("security state re-entered");
	chk_secure_drop: assert property (sSecDrop |->
		sinceLaunch >= LAT_MIN && sinceLaunch <= LAT_MAX)
		else $error("security released without timed erase");
	chk_irq_masked: assert property (sMaskOff |=> !irq)
		else $error("interrupt high with mask clear");
endmodule

bind fes_sequencer fes_sequencer_assertions #(.ERASE_CNT(ERASE_CNT)) chk (
	.mclk(mclk), .rstn(rstn), .clkEn(clkEn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.irq(irq), .secured(secured));

// ---- flash_erase_unsecure_sequencer_tb_top.sv ----
// Self-checking bench for the flash command sequencer
`timescale 1ns/100ps
module flash_erase_unsecure_sequencer_tb_top
	import fes_pkg::*;
;
	localparam int CNT = 4;
	localparam logic [31:0] CFG = 32'h000C0000;
	logic mclk = 0, rstn = 0, clkEn = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, irq, secured;
	int failures = 0, numChecks = 0, cycles = 0;
	fes_sequencer #(.ERASE_CNT(CNT)) uut (.mclk(mclk), .rstn(rstn),
		.clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .secured(secured));
	always #20 mclk = ~mclk;
	task automatic end_sim;
		$display("checks %0d mismatches %0d", numChecks, failures);
		if (failures == 0 && numChecks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			end_sim();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do @(posedge mclk); while (pready !== 1'h1);
		r = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'h1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		apb(1'h0, a, 32'h0, r);
		check(r, e);
	endtask
	// Loads both command words, sets the final index, then launches
	task automatic ld(input logic [15:0] w0, w1, input logic [2:0] fin);
		wr(OFS_INDEX, 32'h0);
		wr(OFS_DATA, {16'h0, w0});
		wr(OFS_INDEX, 32'h1);
		wr(OFS_DATA, {16'h0, w1});
		wr(OFS_INDEX, {29'h0, fin});
		wr(OFS_STATUS, 32'h80);
	endtask
	task automatic wait_done;
		logic [31:0] r;
		int n;
		r = 32'h0;
		n = 0;
		while (r[ST_COMMAND_COMPLETE_FLAG] !== 1'h1 && n < 50) begin
			apb(1'h0, OFS_STATUS, 32'h0, r);
			n++;
		end
	endtask
	task automatic t_reset;
		rd(OFS_STATUS, 32'h80);
		rd(OFS_SECURE, 32'h1);
		rd(8'h1C, 32'h0);
		wr(OFS_INDEX, 32'h5);
		rd(OFS_INDEX, 32'h5);
		// Writes are lost while the clock enable is low
		clkEn <= 1'b0;
		wr(OFS_INDEX, 32'h2);
		clkEn <= 1'b1;
		rd(OFS_INDEX, 32'h5);
		wr(OFS_CONFIG, 32'h00001F00);
		rd(OFS_CONFIG, 32'h00001F00);
		$display("reset test done");
	endtask
	// A launch that must be refused at once, without an erase
	task automatic refuse(input logic [31:0] cf, input logic [15:0] w0,
		w1, input logic [2:0] fin, input logic [31:0] exp);
		wr(OFS_CONFIG, cf);
		ld(w0, w1, fin);
		rd(OFS_STATUS, exp);
		wr(OFS_STATUS, 32'h30);
	endtask
	task automatic t_refuse;
		refuse(CFG, 16'h0A00, 16'h0400, 3'h0, 32'hA0);
		refuse(CFG, 16'h0A02, 16'h0400, 3'h1, 32'hA0);
		refuse(CFG, 16'h0A00, 16'h0404, 3'h1, 32'hA0);
		refuse(32'h80000, 16'h0A00, 16'h0400, 3'h1, 32'hA0);
		refuse(CFG, 16'h0B00, 16'h0000, 3'h1, 32'hA0);
		refuse(32'h40000, 16'h0B00, 16'h0000, 3'h0, 32'hA0);
		refuse(32'hD0000, 16'h0A00, 16'h0000, 3'h1, 32'h90);
		refuse(32'hE0000, 16'h0B00, 16'h0000, 3'h0, 32'h90);
		rd(OFS_SECURE, 32'h1);
		$display("refusal test done");
	endtask
	task automatic t_irq;
		wr(OFS_IRQ_MASK, 32'h2);
		@(negedge mclk);
		check({31'h0, irq}, 32'h1);
		wr(OFS_IRQ_MASK, 32'h0);
		@(negedge mclk);
		check({31'h0, irq}, 32'h0);
		wr(OFS_IRQ_MASK, 32'h2);
		wr(OFS_IRQ_STAT, 32'h3);
		@(negedge mclk);
		check({31'h0, irq}, 32'h0);
		$display("interrupt test done");
	endtask
	task automatic t_erase;
		wr(OFS_CONFIG, CFG | 32'hC0000000);
		ld(16'h0A00, 16'h0408, 3'h1);
		wr(OFS_INDEX, 32'h5);
		wait_done();
		rd(OFS_STATUS, 32'h83);
		rd(OFS_INDEX, 32'h1);
		$display("erase test done");
	endtask
	task automatic t_unsec;
		wr(OFS_CONFIG, CFG | 32'h40000000);
		ld(16'h0B00, 16'h0, 3'h0);
		wait_done();
		rd(OFS_STATUS, 32'h82);
		rd(OFS_SECURE, 32'h1);
		wr(OFS_CONFIG, CFG);
		ld(16'h0B00, 16'h0, 3'h0);
		wait_done();
		rd(OFS_STATUS, 32'h80);
		rd(OFS_SECURE, 32'h0);
		$display("unsecure test done");
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		rstn <= 1'h1;
		t_reset();
		t_refuse();
		t_irq();
		t_erase();
		t_unsec();
		end_sim();
	end
endmodule
